// [logic/flash_bus_cycle.v]
/*
 one flash bus cycle: a read (address, chip and output enable low, write strobe high)
 or a write (chip and write strobe low, output enable high). assumes synchronous pin inputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defs.vh"
module flash_bus_cycle #(
   parameter AW = 24,
   parameter DW = 16,
   parameter ACC_CYC = `ADDR_ACCESS_CYC,
   parameter PACC_CYC = `PAGE_ACCESS_CYC
) (
   input wire clk,
   input wire nrst,
   input wire start,
   input wire is_write,
   input wire page_hit,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   input wire [DW-1:0] data_pins_i,
   output reg [AW-1:0] addr_pins,
   output reg [DW-1:0] data_pins_o,
   output reg data_pins_oe,
   output reg ce_n,
   output reg oe_n,
   output reg we_n,
   output reg done,
   output reg [DW-1:0] rdata
);
   localparam S_IDLE = 2'h0;
   localparam S_LOW = 2'h1;
   localparam S_HIGH = 2'h2;
   localparam integer WP_INT = `WRITE_PULSE_CYC;
   localparam integer WH_INT = `WRITE_HIGH_CYC;
   reg [1:0] st_q;
   reg [7:0] cnt_q;
   reg wr_q;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         addr_pins <= {AW{1'b0}};
         data_pins_o <= {DW{1'b0}};
         data_pins_oe <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         done <= 1'b0;
         rdata <= {DW{1'b0}};
      end else begin
         done <= 1'b0;
         case (st_q)
            S_IDLE: begin
               if (start) begin
                  wr_q <= is_write;
                  addr_pins <= addr;
                  ce_n <= 1'b0;
                  if (is_write) begin
                     // write strobe low, output enable high, data driven
                     we_n <= 1'b0;
                     oe_n <= 1'b1;
                     data_pins_o <= wdata;
                     data_pins_oe <= 1'b1;
                     cnt_q <= WP_INT[7:0];
                  end else begin
                     // read keeps write strobe high
                     we_n <= 1'b1;
                     oe_n <= 1'b0;
                     data_pins_oe <= 1'b0;
                     cnt_q <= page_hit ? PACC_CYC[7:0] : ACC_CYC[7:0];
                  end
                  st_q <= S_LOW;
               end
            end
            S_LOW: begin
               if (cnt_q > 8'h01) begin
                  cnt_q <= cnt_q - 8'h01;
               end else begin
                  if (!wr_q) begin
                     rdata <= data_pins_i;
                  end
                  // device latches data on this rising edge
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  cnt_q <= WH_INT[7:0];
                  st_q <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (cnt_q > 8'h01) begin
                  cnt_q <= cnt_q - 8'h01;
               end else begin
                  data_pins_oe <= 1'b0;
                  if (wr_q) begin
                     ce_n <= 1'b1;
                  end
                  done <= 1'b1;
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // flash_bus_cycle
`default_nettype wire

// [logic/flash_host.v]
/*
 host controller for a parallel nor flash: array/page reads, single word program with
 status polling, identifier readout and exit, hardware reset pulse.
 assumes the flash pins are wired directly and inputs are synchronous to clk.
*/
// Behaviour
// - host reads: address, ce/oe low, we high
// - identifier command never while programming
// - reset command leaves identifier mode
// - writes: ce/we low, oe high
// - word program is four write cycles
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defs.vh"
module flash_host #(
   parameter AW = 24,
   parameter DW = 16,
   parameter ACC_CYC = `ADDR_ACCESS_CYC,
   parameter PACC_CYC = `PAGE_ACCESS_CYC,
   parameter RST_CYC = `RESET_PULSE_CYC
) (
   input wire clk,
   input wire nrst,
   input wire req_valid,
   input wire [2:0] req_op,
   input wire [AW-1:0] req_addr,
   input wire [DW-1:0] req_wdata,
   output reg req_ready,
   output reg resp_valid,
   output reg [DW-1:0] resp_rdata,
   output reg resp_error,
   output reg busy,
   input wire [DW-1:0] data_pins_i,
   output reg [AW-1:0] addr_pins,
   output reg [DW-1:0] data_pins_o,
   output reg data_pins_oe,
   output reg ce_n,
   output reg oe_n,
   output reg we_n,
   output reg reset_n,
   output reg word_mode
);
   localparam S_IDLE = 3'h0;
   localparam S_CYC = 3'h1;
   localparam S_POLL = 3'h2;
   localparam S_RST = 3'h3;
   localparam S_RESP = 3'h4;
   reg [2:0] st_q;
   reg [2:0] op_q;
   reg [AW-1:0] addr_q;
   reg [DW-1:0] wdata_q;
   reg [1:0] step_q;
   reg [1:0] nsteps_q;
   reg [DW-1:0] prev_q;
   reg poll_first_q;
   reg [19:0] poll_q;
   reg [15:0] rst_q;
   reg page_ok_q;
   reg [AW-1:`PAGE_LSB] page_q;
   reg ident_q;
   reg cyc_busy_q;
   reg cyc_start;
   reg cyc_write;
   reg [AW-1:0] cyc_addr;
   reg [DW-1:0] cyc_wdata;
   wire [AW-1:0] b_addr_pins;
   wire [DW-1:0] b_data_o;
   wire b_oe;
   wire b_ce_n;
   wire b_oe_n;
   wire b_we_n;
   wire b_done;
   wire [DW-1:0] b_rdata;
   wire page_hit;
   // same page and chip enable kept low since last read
   assign page_hit = page_ok_q && (page_q == cyc_addr[AW-1:`PAGE_LSB]) && !cyc_write;
   // command step table: unlock, unlock, command, then data/address
   function [AW+DW:0] step_word;
      input [2:0] op;
      input [1:0] step;
      input [AW-1:0] a;
      input [DW-1:0] d;
      begin
         case (step)
            2'h0: step_word = {1'b1, `UNLOCK_ADDR1, `UNLOCK_DATA1};
            2'h1: step_word = {1'b1, `UNLOCK_ADDR2, `UNLOCK_DATA2};
            2'h2: step_word = {1'b1, `UNLOCK_ADDR1, (op == `OP_IDENT) ? `CMD_IDENT : `CMD_PROGRAM};
            default: step_word = {1'b1, a, d};
         endcase
         if (op == `OP_EXIT_IDENT) begin
            step_word = {1'b1, a, `CMD_RESET};
         end
         if (op == `OP_READ) begin
            step_word = {1'b0, a, d};
         end
      end
   endfunction
   always @* begin
      {cyc_write, cyc_addr, cyc_wdata} = step_word(op_q, step_q, addr_q, wdata_q);
      cyc_start = (st_q == S_CYC) && (step_q != nsteps_q || !b_done) && !cyc_busy_q;
      if (st_q == S_POLL) begin
         cyc_write = 1'b0;
         cyc_addr = addr_q;
         cyc_start = !cyc_busy_q;
      end
   end
   flash_bus_cycle #(.AW(AW), .DW(DW), .ACC_CYC(ACC_CYC + 1), .PACC_CYC(PACC_CYC + 1)) u_cycle (
      .clk(clk),
      .nrst(nrst),
      .start(cyc_start),
      .is_write(cyc_write),
      .page_hit(page_hit),
      .addr(cyc_addr),
      .wdata(cyc_wdata),
      .data_pins_i(data_pins_i),
      .addr_pins(b_addr_pins),
      .data_pins_o(b_data_o),
      .data_pins_oe(b_oe),
      .ce_n(b_ce_n),
      .oe_n(b_oe_n),
      .we_n(b_we_n),
      .done(b_done),
      .rdata(b_rdata)
   );
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_pins <= {AW{1'b0}};
         data_pins_o <= {DW{1'b0}};
         data_pins_oe <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
      end else begin
         addr_pins <= b_addr_pins;
         data_pins_o <= b_data_o;
         data_pins_oe <= b_oe;
         ce_n <= b_ce_n | (st_q == S_RST);
         oe_n <= b_oe_n;
         we_n <= b_we_n;
      end
   end
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         op_q <= `OP_READ;
         addr_q <= {AW{1'b0}};
         wdata_q <= {DW{1'b0}};
         step_q <= 2'h0;
         nsteps_q <= 2'h0;
         prev_q <= {DW{1'b0}};
         poll_first_q <= 1'b0;
         poll_q <= 20'h00000;
         rst_q <= 16'h0000;
         page_ok_q <= 1'b0;
         page_q <= {(AW-`PAGE_LSB){1'b0}};
         ident_q <= 1'b0;
         cyc_busy_q <= 1'b0;
         req_ready <= 1'b0;
         resp_valid <= 1'b0;
         resp_rdata <= {DW{1'b0}};
         resp_error <= 1'b0;
         busy <= 1'b0;
         reset_n <= 1'b1;
         word_mode <= 1'b1;
      end else begin
         resp_valid <= 1'b0;
         word_mode <= 1'b1; // 16-bit configuration
         if (cyc_start) begin
            cyc_busy_q <= 1'b1;
         end else if (b_done) begin
            cyc_busy_q <= 1'b0;
         end
         if (b_ce_n) begin
            page_ok_q <= 1'b0;
         end
         case (st_q)
            S_IDLE: begin
               req_ready <= 1'b1;
               busy <= 1'b0;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  busy <= 1'b1;
                  op_q <= req_op;
                  addr_q <= req_addr;
                  wdata_q <= req_wdata;
                  step_q <= 2'h0;
                  resp_error <= 1'b0;
                  case (req_op)
                     `OP_READ: begin
                        // array read needs no command after reset
                        nsteps_q <= 2'h0;
                        step_q <= 2'h0;
                        st_q <= S_CYC;
                     end
                     `OP_PROGRAM: begin
                        nsteps_q <= 2'h3; // four write cycles, any address
                        st_q <= S_CYC;
                     end
                     `OP_IDENT: begin
                        nsteps_q <= 2'h2; // command sequence only
                        st_q <= S_CYC;
                     end
                     `OP_EXIT_IDENT: begin
                        nsteps_q <= 2'h0;
                        st_q <= S_CYC;
                     end
                     `OP_HW_RESET: begin
                        rst_q <= RST_CYC[15:0];
                        reset_n <= 1'b0; // aborts program
                        st_q <= S_RST;
                     end
                     default: begin
                        resp_error <= 1'b1;
                        st_q <= S_RESP;
                     end
                  endcase
               end
            end
            S_CYC: begin
               if (b_done) begin
                  if (step_q == nsteps_q) begin
                     resp_rdata <= b_rdata;
                     if (op_q == `OP_READ) begin
                        page_ok_q <= 1'b1;
                        page_q <= addr_q[AW-1:`PAGE_LSB];
                     end else begin
                        page_ok_q <= 1'b0;
                     end
                     if (op_q == `OP_IDENT) begin
                        ident_q <= 1'b1;
                     end
                     if (op_q == `OP_EXIT_IDENT) begin
                        ident_q <= 1'b0;
                     end
                     if (op_q == `OP_PROGRAM) begin
                        poll_first_q <= 1'b1;
                        poll_q <= 20'h00000;
                        st_q <= S_POLL; // wait for completion
                     end else begin
                        st_q <= S_RESP;
                     end
                  end else begin
                     step_q <= step_q + 2'h1;
                  end
               end
            end
            S_POLL: begin
               if (b_done) begin
                  prev_q <= b_rdata;
                  poll_first_q <= 1'b0;
                  poll_q <= poll_q + 20'h00001;
                  // toggle bit stops toggling when finished, flash back in array read
                  if (!poll_first_q && (prev_q[6] == b_rdata[6])) begin
                     resp_rdata <= b_rdata;
                     // a 0 cannot be raised to 1
                     resp_error <= (b_rdata != (wdata_q & b_rdata)) || (b_rdata != wdata_q);
                     st_q <= S_RESP;
                  end else if (poll_q == `POLL_LIMIT) begin
                     resp_error <= 1'b1;
                     st_q <= S_RESP;
                  end
               end
            end
            S_RST: begin
               if (rst_q > 16'h0001) begin
                  rst_q <= rst_q - 16'h0001;
               end else begin
                  reset_n <= 1'b1;
                  ident_q <= 1'b0;
                  page_ok_q <= 1'b0;
                  st_q <= S_RESP;
               end
            end
            S_RESP: begin
               resp_valid <= 1'b1;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // flash_host
`default_nettype wire

// [logic/flash_host_defs.vh]
/*
 constants for the parallel flash host controller: timing counts, command codes,
 identifier offsets. assumes a 100 MHz clock.
*/
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH
`define CLK_PERIOD_NS 10
`define ADDR_ACCESS_NS 70
`define ADDR_ACCESS_CYC ((`ADDR_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_ACCESS_NS 20
`define PAGE_ACCESS_CYC ((`PAGE_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS 40
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_HIGH_NS 30
`define WRITE_HIGH_CYC ((`WRITE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_NS 500
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UNLOCK_ADDR1 24'h000555
`define UNLOCK_ADDR2 24'h0002aa
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_DATA2 16'h0055
`define CMD_PROGRAM 16'h00a0
`define CMD_IDENT 16'h0090
`define CMD_RESET 16'h00f0
`define ID_MFR_OFS 24'h000000
`define ID_DEV1_OFS 24'h000001
`define ID_DEV2_OFS 24'h00000e
`define ID_DEV3_OFS 24'h00000f
`define ID_BYTE_DEV1_OFS 24'h000002
`define ID_BYTE_DEV2_OFS 24'h00001c
`define ID_BYTE_DEV3_OFS 24'h00001e
`define PAGE_LSB 3
`define POLL_LIMIT 20'hfffff
`define OP_READ 3'h0
`define OP_PROGRAM 3'h1
`define OP_IDENT 3'h2
`define OP_EXIT_IDENT 3'h3
`define OP_HW_RESET 3'h4
`endif

// [tb/flash_host_asserts.sv]
/* pin and request-port assertions for flash_host.
   assumes the bind hands on the host reset-pulse count. */
`timescale 1ns/10ps
`default_nettype none
module flash_host_asserts #(parameter RST_CYC = 50) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_ready,
   input wire logic resp_valid,
   input wire logic busy,
   input wire logic [23:0] addr_pins,
   input wire logic [15:0] data_pins_o,
   input wire logic data_pins_oe,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic word_mode
);
   logic [15:0] low_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // cycles the flash reset pin has been low
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_q <= 16'h0000;
      end else begin
         low_q <= reset_n ? 16'h0000 : low_q + 16'h0001;
      end
   end
   read_strobes_a: assert property (!oe_n |-> we_n && !ce_n && !data_pins_oe)
      else $error("read strobes wrong");
   write_strobes_a: assert property (!we_n |-> oe_n && !ce_n && data_pins_oe)
      else $error("write strobes wrong");
   write_hold_a: assert property (!we_n && !$past(we_n) |-> $stable(addr_pins) && $stable(data_pins_o))
      else $error("write address or data moved");
   write_pulse_a: assert property ($fell(we_n) |-> !we_n [*4] ##1 we_n)
      else $error("write pulse length wrong");
   access_wait_a: assert property ($fell(ce_n) |-> !resp_valid [*7])
      else $error("answer before access time");
   resp_pulse_a: assert property (resp_valid |=> !resp_valid && req_ready)
      else $error("answer not one cycle");
   busy_refuse_a: assert property (busy |-> !req_ready)
      else $error("ready while busy");
   reset_len_a: assert property ($rose(reset_n) |-> low_q >= RST_CYC)
      else $error("flash reset pulse short");
   word_pins_a: assert property (word_mode)
      else $error("width pin low");
endmodule // flash_host_asserts
bind flash_host flash_host_asserts #(.RST_CYC(RST_CYC)) flash_host_asserts_inst (.clk(clk), .nrst(nrst),
   .req_ready(req_ready), .resp_valid(resp_valid), .busy(busy), .addr_pins(addr_pins),
   .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
   .reset_n(reset_n), .word_mode(word_mode));
`default_nettype wire

// [tb/flash_model.sv]
/* behavioural parallel nor flash answering flash_host.
   assumes word mode and pins driven straight from the host. */
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defs.vh"
module flash_model #(
   parameter MFR = 16'h00c3, // arbitrary id values
   parameter DEV1 = 16'h1234,
   parameter DEV2 = 16'h5678,
   parameter DEV3 = 16'h0abc,
   parameter PROT_SECT = 8'h7f,
   parameter OE_NS = 20
) (
   input wire logic [23:0] addr_pins,
   input wire logic [15:0] data_pins_o,
   input wire logic data_pins_oe,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic word_mode,
   input wire logic slow,
   output logic [15:0] data_pins_i
);
   logic [15:0] mem [int];
   logic [23:0] lat_a, last_a, pa;
   logic [15:0] pd;
   logic wr = 0, ident = 0, prog = 0, tog = 0, pg_ok = 0;
   int step = 0;
   realtime t_a = 0, t_o = 0, t_p = 0, need = 0;
   function automatic logic [15:0] rd(input logic [23:0] a);
      return mem.exists(a) ? mem[a] : {a[7:0] ^ 8'h3c, a[15:8]};
   endfunction
   // id register, sector taken from the top address bits
   function automatic logic [15:0] id_val(input logic [23:0] a);
      case (a[7:0])
         8'h00: return MFR;
         8'h01: return DEV1;
         8'h0e: return DEV2;
         8'h0f: return DEV3;
         8'h02: return {15'h0000, a[23:16] == PROT_SECT};
         default: return 16'h0000;
      endcase
   endfunction
   task automatic cmd(input logic [23:0] a, input logic [15:0] d);
      if (!prog) begin
         if (d == `CMD_RESET) begin
            step = 0;
            ident = 0;
         end else if (step == 0) begin
            step = (a[11:0] == 12'h555 && d == `UNLOCK_DATA1) ? 1 : 0;
         end else if (step == 1) begin
            step = (a[11:0] == 12'h2aa && d == `UNLOCK_DATA2) ? 2 : 0;
         end else if (step == 2) begin
            ident = ident | (a[11:0] == 12'h555 && d == `CMD_IDENT);
            step = (a[11:0] == 12'h555 && d == `CMD_PROGRAM) ? 3 : 0;
         end else begin
            pa = a;
            pd = d;
            prog = 1;
            step = 0;
            t_p = $realtime + (slow ? 2000 : 200);
         end
      end
   endtask
   always @(negedge we_n or negedge ce_n) begin
      if (!we_n && !ce_n) begin
         lat_a = addr_pins;
         wr = 1;
      end
   end
   always @(posedge we_n or posedge ce_n) begin
      if (wr) begin
         wr = 0;
         cmd(lat_a, data_pins_o);
      end
   end
   always @(addr_pins) begin
      need = (pg_ok && addr_pins[23:3] == last_a[23:3]) ? `PAGE_ACCESS_NS : `ADDR_ACCESS_NS;
      t_a = $realtime;
      last_a = addr_pins;
   end
   always @(negedge ce_n) begin
      need = `ADDR_ACCESS_NS;
      t_a = $realtime;
   end
   always @(posedge ce_n) pg_ok = 0;
   always @(negedge oe_n) begin
      t_o = $realtime;
      tog = prog ? ~tog : tog;
   end
   initial begin
      data_pins_i = 16'h0000;
      #0.5;
      forever begin
         if (!reset_n) begin
            prog = 0;
            step = 0;
            ident = 0;
         end
         if (prog && $realtime >= t_p) begin
            mem[pa] = rd(pa) & pd;
            prog = 0;
         end
         if (data_pins_oe) begin
            data_pins_i = data_pins_o;
         end else if (!ce_n && !oe_n && we_n && reset_n && $realtime >= t_a + need - 0.5
                      && $realtime >= t_o + OE_NS - 0.5) begin
            data_pins_i = prog ? {8'h00, ~pd[7], tog, 6'h00} : ident ? id_val(addr_pins) : rd(addr_pins);
            pg_ok = 1;
         end else begin
            data_pins_i = ~data_pins_i;
         end
         #1;
      end
   end
endmodule // flash_model
`default_nettype wire

// [tb/tb.sv]
/* self-checking bench for flash_host with a behavioural flash.
   assumes default host parameters and a 100 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defs.vh"
module tb;
   localparam [15:0] MFR = 16'h00c3; // arbitrary id values
   localparam [15:0] DEV1 = 16'h1234;
   localparam [15:0] DEV2 = 16'h5678;
   localparam [15:0] DEV3 = 16'h0abc;
   logic clk, nrst, req_valid, req_ready, resp_valid, resp_error, busy, slow, er;
   logic data_pins_oe, ce_n, oe_n, we_n, reset_n, word_mode;
   logic [2:0] req_op;
   logic [23:0] req_addr, addr_pins;
   logic [15:0] req_wdata, resp_rdata, data_pins_i, data_pins_o, rd;
   logic [15:0] sh [int];
   int fails = 0, n_compared = 0;
   flash_host flash_host_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_rdata(resp_rdata), .resp_error(resp_error), .busy(busy), .data_pins_i(data_pins_i),
      .addr_pins(addr_pins), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n), .word_mode(word_mode));
   flash_model #(.MFR(MFR), .DEV1(DEV1), .DEV2(DEV2), .DEV3(DEV3)) flash_model_inst (
      .addr_pins(addr_pins), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n), .word_mode(word_mode), .slow(slow),
      .data_pins_i(data_pins_i));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   function automatic logic [15:0] cur(input logic [23:0] a);
      return sh.exists(a) ? sh[a] : {a[7:0] ^ 8'h3c, a[15:8]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one request, held until taken, then wait for the answer
   task automatic op(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d);
      int k;
      @(posedge clk);
      #1;
      req_valid = 1;
      req_op = c;
      req_addr = a;
      req_wdata = d;
      k = 0;
      do begin @(posedge clk); k++; end while (req_ready !== 1'b1 && k < 1000);
      #1;
      req_valid = 0;
      k = 0;
      do begin @(posedge clk); k++; end while (resp_valid !== 1'b1 && k < 5000);
      chk({15'h0000, resp_valid}, 16'h0001);
      rd = resp_rdata;
      er = resp_error;
   endtask
   task automatic rd_chk(input logic [23:0] a, input logic [15:0] e);
      op(`OP_READ, a, 16'h0000);
      chk(rd, e);
      chk({15'h0000, er}, 16'h0000);
   endtask
   task automatic pg_chk(input logic [23:0] a, input logic [15:0] d);
      logic [15:0] e;
      e = cur(a) & d;
      op(`OP_PROGRAM, a, d);
      chk(rd, e);
      chk({15'h0000, er}, {15'h0000, e !== d});
      sh[a] = e;
      rd_chk(a, e);
   endtask
   task automatic t_read();
      logic [23:0] pl [5] = '{24'h012340, 24'h012341, 24'h012347, 24'h012348, 24'h012340};
      rd_chk(24'h000123, cur(24'h000123));
      foreach (pl[i]) rd_chk(pl[i], cur(pl[i]));
      $display("t_read done");
   endtask
   task automatic t_prog();
      pg_chk(24'h3f0010, 16'h2400);
      pg_chk(24'h010005, 16'h1100);
      pg_chk(24'h3f0010, 16'h0400);
      pg_chk(24'h3f0010, 16'h0c00);
      @(posedge clk);
      #1;
      slow = 1;
      pg_chk(24'h7f0100, 16'h0001);
      slow = 0;
      $display("t_prog done");
   endtask
   task automatic t_ident();
      op(`OP_IDENT, 24'h000000, 16'h0000);
      chk({15'h0000, er}, 16'h0000);
      rd_chk(`ID_MFR_OFS, MFR);
      rd_chk(`ID_DEV1_OFS, DEV1);
      rd_chk(`ID_DEV2_OFS, DEV2);
      rd_chk(`ID_DEV3_OFS, DEV3);
      rd_chk(24'h7f0002, 16'h0001);
      rd_chk(24'h120002, 16'h0000);
      op(`OP_EXIT_IDENT, 24'h000000, 16'h0000);
      chk({15'h0000, er}, 16'h0000);
      rd_chk(24'h000001, cur(24'h000001));
      $display("t_ident done");
   endtask
   task automatic t_hwrst();
      op(`OP_IDENT, 24'h000000, 16'h0000);
      op(`OP_HW_RESET, 24'h000000, 16'h0000);
      chk({15'h0000, er}, 16'h0000);
      rd_chk(24'h000000, cur(24'h000000));
      op(3'h7, 24'h000000, 16'h0000);
      chk({15'h0000, er}, 16'h0001);
      $display("t_hwrst done");
   endtask
   initial begin
      nrst = 0;
      req_valid = 0;
      req_op = 3'h0;
      req_addr = 24'h000000;
      req_wdata = 16'h0000;
      slow = 0;
      repeat (12) @(posedge clk);
      #1;
      nrst = 1;
      t_read();
      t_prog();
      t_ident();
      t_hwrst();
      conclude();
   end
   initial begin
      #200000;
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      conclude();
   end
endmodule // tb
`default_nettype wire
